/* cca_pkg.sv */
// Purpose: Shared constants and types for the counter array block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Offsets, field positions, resets and divider counts live here
package cca_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned CH_N      = 5;      // Capture/compare modules
  localparam int unsigned WD_CH     = 4;      // Module with watchdog

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL   = 8'h00; // Run and clock source
  localparam logic [7:0]  OFF_COUNT  = 8'h04; // Time base value
  localparam logic [7:0]  OFF_STATUS = 8'h08; // Sticky events, W1C
  localparam logic [7:0]  OFF_MASK   = 8'h0C; // Interrupt mask
  localparam logic [7:0]  OFF_WDOG   = 8'h10; // Watchdog enable/lock
  localparam logic [7:0]  OFF_MODE0  = 8'h20; // Module mode, step 4
  localparam logic [7:0]  OFF_VAL0   = 8'h40; // Module value, step 4

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_RUN   = 0;     // Counter run
  localparam int unsigned CTRL_SEL   = 1;     // Source, bits 3:1
  localparam int unsigned WDOG_EN    = 0;     // Watchdog enable
  localparam int unsigned WDOG_LOCK  = 1;     // Permanent lock
  localparam int unsigned MODE_RISE  = 3;     // Capture on rising
  localparam int unsigned MODE_FALL  = 4;     // Capture on falling
  localparam int unsigned ST_OVF     = 0;     // Overflow status bit

  // ==========================================================
  // Reset values
  localparam logic [15:0] VAL_RST    = 16'h0000;
  localparam logic [15:0] WD_VAL_RST = 16'hFFFF; // Longest first timeout
  localparam logic        WD_EN_RST  = 1'b1;

  // ==========================================================
  // Divider counts
  localparam logic [3:0]  DIV12_LAST = 4'hB;  // Divide by 12
  localparam logic [3:0]  DIV4_LAST  = 4'h3;  // Divide by 4
  localparam logic [2:0]  OSC8_LAST  = 3'h7;  // Divide by 8

  // ==========================================================
  // Counter clock sources
  typedef enum logic [2:0] {
    SRC_DIV12 = 3'h0,
    SRC_DIV4  = 3'h1,
    SRC_T0OVF = 3'h2,
    SRC_EXT   = 3'h3,
    SRC_SYS   = 3'h4,
    SRC_OSC8  = 3'h5
  } src_t;

  // Module operating modes
  typedef enum logic [2:0] {
    M_OFF   = 3'h0,
    M_CAPT  = 3'h1,
    M_TIMER = 3'h2,
    M_HSO   = 3'h3,
    M_PWM8  = 3'h4,
    M_PWM16 = 3'h5,
    M_FREQ  = 3'h6
  } mode_t;

endpackage

/* cca_tick_gen.sv */
// Purpose: Selects the time base advance strobe among six sources
// Assumes: Slow external clocks are well below pclk / 2
// Notes:   Output is a one-cycle enable, never a derived clock
`timescale 1ns/1ps
`default_nettype none
module cca_tick_gen (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control
  input  wire cca_pkg::src_t src,
  input  wire logic          run,
  input  wire logic          halt,
  // Sources
  input  wire logic          timer0_ovf,
  input  wire logic          ext_count_clock_in,
  input  wire logic          ext_osc_clk,
  // Strobe
  output logic               tick
);
  import cca_pkg::*;

  // ==========================================================
  // Dividers and synchronisers
  logic [3:0] div12_reg;   // System clock / 12
  logic [3:0] div4_reg;    // System clock / 4
  logic [2:0] osc_reg;     // Oscillator edge count
  logic [1:0] sync1_reg;   // First stage, read by stage two only
  logic [1:0] sync2_reg;   // Stable copies
  logic [1:0] last_reg;    // For edge detection

  wire        p12   = (div12_reg == DIV12_LAST);
  wire        p4    = (div4_reg == DIV4_LAST);
  wire [1:0]  rise  = sync2_reg & ~last_reg;
  wire        p_osc = rise[1] && (osc_reg == OSC8_LAST);

  // Free-running dividers; they do not stall, only the strobe does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_reg <= 4'h0;
      div4_reg  <= 4'h0;
    end else begin
      div12_reg <= p12 ? 4'h0 : div12_reg + 4'h1;
      div4_reg  <= p4 ? 4'h0 : div4_reg + 4'h1;
    end
  end

  // External clocks brought into pclk before use; R10
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 2'b00;
      sync2_reg <= 2'b00;
      last_reg  <= 2'b00;
      osc_reg   <= 3'h0;
    end else begin
      sync1_reg <= {ext_osc_clk, ext_count_clock_in}; // R10
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
      if (rise[1]) begin
        osc_reg <= osc_reg + 3'h1;
      end
    end
  end

  // Source mux; unused codes never advance the counter
  logic sel_w;
  always_comb begin
    unique case (src)
      SRC_DIV12: sel_w = p12;          // R2
      SRC_DIV4:  sel_w = p4;           // R2
      SRC_T0OVF: sel_w = timer0_ovf;   // R2
      SRC_EXT:   sel_w = rise[0];      // R2
      SRC_SYS:   sel_w = 1'b1;         // R2
      SRC_OSC8:  sel_w = p_osc;        // R2
      default:   sel_w = 1'b0;
    endcase
  end

  // Debug halt freezes the time base
  assign tick = sel_w && run && !halt; // R9

endmodule
`default_nettype wire

/* cca_channel.sv */
// Purpose: One capture/compare module on the shared time base
// Assumes: Pin input is synchronous to pclk
// Notes:   Value register doubles as capture and compare value
`timescale 1ns/1ps
`default_nettype none
module cca_channel #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // Time base
  input  wire logic           tick,
  input  wire logic [15:0]    count,
  // Configuration
  input  wire cca_pkg::mode_t mode,
  input  wire logic           rise_en,
  input  wire logic           fall_en,
  input  wire logic           val_we,
  input  wire logic [15:0]    val_wdata,
  // Pin side
  input  wire logic           pin_in,
  output logic                pin_out,
  // State
  output logic [15:0]         val_q,
  output logic                event_p
);
  import cca_pkg::*;

  // ==========================================================
  // Match and edge terms
  logic        pin_d_reg;   // Previous pin level
  logic [15:0] val_next;
  logic        out_next;

  wire match  = tick && (count == val_q);
  wire lo_m   = tick && (count[7:0] == val_q[7:0]);
  wire edge_r = pin_in && !pin_d_reg;
  wire edge_f = !pin_in && pin_d_reg;
  wire capt   = (mode == M_CAPT) &&
                ((rise_en && edge_r) || (fall_en && edge_f)); // R3
  wire freq_m = (mode == M_FREQ) && lo_m;
  wire [7:0] freq_lo = val_q[7:0] + val_q[15:8];

  // Events: capture, or a compare hit in the match modes
  assign event_p = capt || freq_m ||
                   (match && (mode == M_TIMER || mode == M_HSO)); // R3

  // Value: software write wins, then capture, then reload
  assign val_next = val_we ? val_wdata :
                    capt   ? count :                          // R3
                    freq_m ? {val_q[15:8], freq_lo} : val_q;  // R3

  // Output per mode
  always_comb begin
    out_next = pin_out;
    if (mode == M_HSO && match) begin
      out_next = !pin_out;                                    // R3
    end else if (freq_m) begin
      out_next = !pin_out;                                    // R3
    end else if (mode == M_PWM8) begin
      out_next = (count[7:0] < val_q[7:0]);                   // R3
    end else if (mode == M_PWM16) begin
      out_next = (count < val_q);                             // R3
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q     <= RST_VAL;
      pin_out   <= 1'b0;
      pin_d_reg <= 1'b0;
    end else begin
      val_q     <= val_next;
      pin_out   <= out_next;
      pin_d_reg <= pin_in;
    end
  end

  // ==========================================================
  // Checks
  property p_capture_takes_count;
    @(posedge pclk) disable iff (!presetn)
      (capt && !val_we) |=> (val_q == $past(count));
  endproperty
  a_capture_takes_count: assert property (p_capture_takes_count) // R3
    else $error("capture did not store the counter value");

endmodule
`default_nettype wire

/* cca_top.sv */
// Purpose: Counter array with five capture/compare modules on APB
// Assumes: Single pclk domain, APB slave with zero wait states
// Notes:   Module 4 doubles as watchdog, enabled out of reset
//
// Function
// R1: One 16-bit time base, five modules
// R2: Counter clock from six selectable sources
// R3: Modules do capture, timer, HSO, PWM, frequency
// R4: Module 4 watchdog can reset system
// R5: Watchdog enabled after every reset
// R6: Software lock keeps watchdog enabled
// R7: Software can disable watchdog reset source
// R8: Module pins and count clock reach crossbar
// R9: Counter stalls while debugger halts CPU
// R10: External clocks synchronised before counting
// R11: Counter wraps to zero, sets overflow flag
`timescale 1ns/1ps
`default_nettype none
module cca_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Counter clock sources
  input  wire logic        timer0_ovf,
  input  wire logic        ext_count_clock_in,
  input  wire logic        ext_osc_clk,
  // Debug
  input  wire logic        debug_halt,
  // Crossbar side module pins
  input  wire logic [4:0]  cc_in,
  output logic [4:0]       cc_out,
  // System
  output logic             irq,
  output logic             wd_reset_req
);
  import cca_pkg::*;

  // ==========================================================
  // State
  logic        run_reg;          // Counter run bit
  logic [2:0]  sel_reg;          // Clock source code
  logic [15:0] count_reg;        // Shared time base
  logic [15:0] count_next;
  logic [5:0]  status_reg;       // Sticky events
  logic [5:0]  status_next;
  logic [5:0]  mask_reg;         // Interrupt enables
  logic        wd_en_reg;        // Watchdog enable
  logic        wd_en_next;
  logic        wd_lock_reg;      // Watchdog lock, until reset
  logic        wd_rst_reg;       // Reset request pulse
  logic [31:0] prdata_reg;       // Read data, sampled in setup
  logic        slverr_reg;       // Error flag, sampled in setup
  logic [4:0]  mode_reg [CH_N];  // Per-module mode field
  logic [15:0] val_w    [CH_N];  // Per-module value
  logic [CH_N-1:0] ev_w;         // Per-module event strobes
  logic [CH_N-1:0] hit_mode;     // Mode register decode
  logic [CH_N-1:0] hit_val;      // Value register decode
  logic [31:0] ch_rd;            // Module read data
  logic        tick;             // Time base advance

  // ==========================================================
  // APB decode
  wire setup      = psel && !penable;
  wire wr         = psel && penable && pwrite;
  wire hit_ctrl   = (paddr == OFF_CTRL);
  wire hit_count  = (paddr == OFF_COUNT);
  wire hit_status = (paddr == OFF_STATUS);
  wire hit_mask   = (paddr == OFF_MASK);
  wire hit_wdog   = (paddr == OFF_WDOG);
  wire mapped     = hit_ctrl || hit_count || hit_status ||
                    hit_mask || hit_wdog || (|hit_mode) ||
                    (|hit_val);
  wire cnt_wr     = wr && hit_count;
  wire wdog_wr    = wr && hit_wdog;

  // Zero-wait slave: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = slverr_reg;

  // ==========================================================
  // Time base
  // Watchdog keeps the time base running even when run is clear
  wire cnt_run = run_reg || wd_en_reg;
  wire ovf     = tick && (count_reg == 16'hFFFF) && !cnt_wr; // R11

  cca_tick_gen u_tick (
    .pclk               (pclk),
    .presetn            (presetn),
    .src                (src_t'(sel_reg)),
    .run                (cnt_run),
    .halt               (debug_halt),
    .timer0_ovf         (timer0_ovf),
    .ext_count_clock_in (ext_count_clock_in),
    .ext_osc_clk        (ext_osc_clk),
    .tick               (tick)
  );

  // Software write wins over a count; wrap is the natural rollover
  assign count_next = cnt_wr ? pwdata[15:0] :
                      tick   ? count_reg + 16'h0001 :     // R1 R11
                      count_reg;

  // ==========================================================
  // Modules
  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++) begin : g_ch
      localparam logic [7:0] MODE_OFF = OFF_MODE0 + 8'(4 * gi);
      localparam logic [7:0] VAL_OFF  = OFF_VAL0 + 8'(4 * gi);
      localparam logic [15:0] RV = (gi == WD_CH) ? WD_VAL_RST : VAL_RST;
      // Watchdog owns module 4 while enabled
      wire wd_own = (gi == WD_CH) && wd_en_reg;                // R4
      wire mode_t m_eff = wd_own ? M_OFF : mode_t'(mode_reg[gi][2:0]);

      assign hit_mode[gi] = (paddr == MODE_OFF);
      assign hit_val[gi]  = (paddr == VAL_OFF);

      // Mode register
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_reg[gi] <= 5'h00;
        end else if (wr && hit_mode[gi]) begin
          mode_reg[gi] <= pwdata[4:0];
        end
      end

      cca_channel #(
        .RST_VAL (RV)
      ) u_ch (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (tick),
        .count     (count_reg),                                // R1
        .mode      (m_eff),
        .rise_en   (mode_reg[gi][MODE_RISE]),
        .fall_en   (mode_reg[gi][MODE_FALL]),
        .val_we    (wr && hit_val[gi]),
        .val_wdata (pwdata[15:0]),
        .pin_in    (cc_in[gi]),                                // R8
        .pin_out   (cc_out[gi]),                               // R8
        .val_q     (val_w[gi]),
        .event_p   (ev_w[gi])
      );
    end
  endgenerate

  // Module read data, one decode hit at most
  always_comb begin
    ch_rd = 32'h0000_0000;
    for (int i = 0; i < CH_N; i++) begin
      if (hit_mode[i]) begin
        ch_rd = ch_rd | {27'h0, mode_reg[i]};
      end
      if (hit_val[i]) begin
        ch_rd = ch_rd | {16'h0, val_w[i]};
      end
    end
  end

  // ==========================================================
  // Watchdog
  // Timeout when the time base reaches module 4 value; a write to
  // that value is the kick, so software must keep moving it ahead
  wire wd_fire = wd_en_reg && tick &&
                 (count_reg == val_w[WD_CH]);                  // R4

  // Locking forces enable on; a locked watchdog ignores clears
  assign wd_en_next = wdog_wr ? (pwdata[WDOG_EN] || pwdata[WDOG_LOCK] ||
                                 wd_lock_reg) :                // R6 R7
                      wd_en_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_en_reg   <= WD_EN_RST;                                // R5
      wd_lock_reg <= 1'b0;
      wd_rst_reg  <= 1'b0;
    end else begin
      wd_en_reg   <= wd_en_next;
      wd_lock_reg <= wd_lock_reg || (wdog_wr && pwdata[WDOG_LOCK]); // R6
      wd_rst_reg  <= wd_fire;                                  // R4
    end
  end

  assign wd_reset_req = wd_rst_reg;

  // ==========================================================
  // Interrupt status
  // Set wins over a clear in the same cycle
  wire [5:0] ev_all = {ev_w, ovf};
  wire [5:0] clr    = (wr && hit_status) ? pwdata[5:0] : 6'h00;
  assign status_next = (status_reg & ~clr) | ev_all;           // R11
  assign irq = |(status_reg & mask_reg);

  // ==========================================================
  // Control, counter, status and read path
  wire [31:0] rd_mux =
    ({32{hit_ctrl}}   & {28'h0, sel_reg, run_reg}) |
    ({32{hit_count}}  & {16'h0, count_reg}) |
    ({32{hit_status}} & {26'h0, status_reg}) |
    ({32{hit_mask}}   & {26'h0, mask_reg}) |
    ({32{hit_wdog}}   & {30'h0, wd_lock_reg, wd_en_reg}) |
    ch_rd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg    <= 1'b0;
      sel_reg    <= SRC_DIV12;
      count_reg  <= 16'h0000;
      status_reg <= 6'h00;
      mask_reg   <= 6'h00;
    end else begin
      if (wr && hit_ctrl) begin
        run_reg <= pwdata[CTRL_RUN];
        sel_reg <= pwdata[CTRL_SEL+2:CTRL_SEL];                // R2
      end
      if (wr && hit_mask) begin
        mask_reg <= pwdata[5:0];
      end
      count_reg  <= count_next;
      status_reg <= status_next;
    end
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= mapped ? rd_mux : 32'h0000_0000;
      slverr_reg <= !mapped;
    end
  end

  // ==========================================================
  // Checks
  property p_wd_on_at_release;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> wd_en_reg;
  endproperty
  a_wd_on_at_release: assert property (p_wd_on_at_release) // R5
    else $error("watchdog not enabled after reset");

  property p_lock_holds;
    @(posedge pclk) disable iff (!presetn)
      wd_lock_reg |=> (wd_en_reg && wd_lock_reg) [*3];
  endproperty
  a_lock_holds: assert property (p_lock_holds) // R6
    else $error("locked watchdog was disabled");

  property p_wd_disable;
    @(posedge pclk) disable iff (!presetn)
      (wdog_wr && !wd_lock_reg && !pwdata[WDOG_EN] &&
       !pwdata[WDOG_LOCK]) |=> !wd_en_reg ##1 !wd_rst_reg;
  endproperty
  a_wd_disable: assert property (p_wd_disable) // R7
    else $error("watchdog disable write ignored");

  property p_wd_fire;
    @(posedge pclk) disable iff (!presetn)
      wd_fire |=> wd_reset_req ##1 !wd_reset_req;
  endproperty
  a_wd_fire: assert property (p_wd_fire) // R4
    else $error("watchdog timeout gave no single reset pulse");

  property p_halt_stalls;
    @(posedge pclk) disable iff (!presetn)
      (debug_halt && !cnt_wr) |=> $stable(count_reg);
  endproperty
  a_halt_stalls: assert property (p_halt_stalls) // R9
    else $error("counter moved during debug halt");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      ovf |=> (count_reg == 16'h0000) && status_reg[ST_OVF];
  endproperty
  a_wrap: assert property (p_wrap) // R11
    else $error("counter did not wrap with overflow flag");

  property p_sys_source;
    @(posedge pclk) disable iff (!presetn)
      (sel_reg == SRC_SYS && cnt_run && !debug_halt && !cnt_wr)
        |-> tick ##1 (count_reg == $past(count_reg) + 16'h0001);
  endproperty
  a_sys_source: assert property (p_sys_source) // R2
    else $error("system clock source did not count every cycle");

  property p_tick_step;
    @(posedge pclk) disable iff (!presetn)
      (tick && !cnt_wr) |=> (count_reg == $past(count_reg) + 16'h0001);
  endproperty
  a_tick_step: assert property (p_tick_step) // R1
    else $error("time base did not advance by one");

endmodule
`default_nettype wire

/* cca_far_side.sv */
// Purpose: Far side model: timer 0, count clocks, module pins
// Assumes: Bench calls one task at a time
// Notes:   Clocks stand low between bursts, phase unrelated to pclk
`timescale 1ns/1ps
`default_nettype none
module cca_far_side (
  // Clock
  input  wire logic      pclk,
  // Sources and pins
  output var logic       timer0_ovf,
  output var logic       ext_count_clock_in,
  output var logic       ext_osc_clk,
  output var logic [4:0] cc_in
);
  // ==========================================================
  // Idle levels at time zero
  initial begin
    timer0_ovf = 1'b0;
    ext_count_clock_in = 1'b0;
    ext_osc_clk = 1'b0;
    cc_in = 5'h00;
  end

  // ==========================================================
  // Edge bursts; slow clocks so the two-flop sync never misses
  task automatic burst(input int kind, input int n);
    for (int i = 0; i < n; i++) begin
      if (kind == 0) begin
        @(posedge pclk) timer0_ovf <= 1'b1;
        @(posedge pclk) timer0_ovf <= 1'b0;
      end else if (kind == 1) begin
        #153 ext_count_clock_in = 1'b1;
        #131 ext_count_clock_in = 1'b0;
      end else begin
        #97 ext_osc_clk = 1'b1;
        #103 ext_osc_clk = 1'b0;
      end
    end
  endtask

  // Pin level change, synchronous to pclk
  task automatic pin(input int i, input logic v);
    @(posedge pclk) cc_in[i] <= v;
  endtask
endmodule
`default_nettype wire

/* counter_array_capture_compare_test.sv */
// Purpose: Self-checking bench for the counter array on APB
// Assumes: Zero wait APB slave, one pclk domain
// Notes:   Reads queue their expectation, a monitor compares
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module counter_array_capture_compare_test;
  import cca_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        timer0_ovf, ext_count_clock_in, ext_osc_clk, debug_halt;
  logic        wd_reset_req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [4:0]  cc_in, cc_out;
  int          err_count, cmp_count, n;
  logic [32:0] exp_q[$];  // {pslverr, prdata}
  logic [32:0] exp_v;     // Oldest note, popped exactly once
  int src_a[7] = '{0, 1, 4, 2, 3, 5, 6};
  int knd_a[7] = '{3, 3, 3, 0, 1, 2, 1};  // 3: open halt window
  int n_a[7]   = '{48, 48, 48, 3, 5, 16, 4};
  int exp_a[7] = '{4, 12, 48, 3, 5, 2, 0};

  cca_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer0_ovf(timer0_ovf), .ext_count_clock_in(ext_count_clock_in),
    .ext_osc_clk(ext_osc_clk), .debug_halt(debug_halt), .cc_in(cc_in),
    .cc_out(cc_out), .irq(irq), .wd_reset_req(wd_reset_req));
  cca_far_side i_far (.pclk(pclk), .timer0_ovf(timer0_ovf),
    .ext_count_clock_in(ext_count_clock_in), .ext_osc_clk(ext_osc_clk),
    .cc_in(cc_in));

  // ==========================================================
  // Clock, and a watchdog against hangs
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #400us;
    err_count++;
    final_report();
  end

  // Read monitor: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      // Pop first: the macro names its expected value twice
      exp_v = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end

  // ==========================================================
  // APB master; request held until pready seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    `CHK(irq, e)
    @(posedge pclk);
  endtask
  // Pin output settles one edge after the write that moves it
  task automatic chk_pin(input int i, input logic e);
    repeat (2) @(negedge pclk);
    `CHK(cc_out[i], e)
    @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, debug_halt} = 5'h00;
    paddr = 8'h00; pwdata = 32'h0;
    void'($urandom(32'h4431));
    do_reset();
    rd(OFF_CTRL, 33'h0);
    rd(OFF_WDOG, 33'h1);
    rd(OFF_VAL0 + 8'h10, {17'h0, WD_VAL_RST});
    rd(8'hFC, 33'h1_0000_0000);
    xfer(1'b1, OFF_WDOG, 32'h0);
    rd(OFF_WDOG, 33'h0);
    // Every mode code, random edge selects
    for (int m = 0; m < 7; m++) begin
      v = ($urandom & 32'h18) | m;
      xfer(1'b1, OFF_MODE0, v);
      rd(OFF_MODE0, {1'b0, v});
    end
    for (int i = 0; i < 4; i++) begin
      v = $urandom & 32'hFFFF;
      xfer(1'b1, OFF_VAL0 + 8'(4 * i), v);
      rd(OFF_VAL0 + 8'(4 * i), {1'b0, v});
    end
    // Wrap under halt gating, then stall and capture
    debug_halt <= 1'b1;
    xfer(1'b1, OFF_MODE0, 32'h09);
    xfer(1'b1, OFF_CTRL, 32'h09);
    xfer(1'b1, OFF_COUNT, 32'hFFFA);
    xfer(1'b1, OFF_STATUS, 32'h3F);
    xfer(1'b1, OFF_MASK, 32'h01);
    chk_irq(1'b0);
    debug_halt <= 1'b0;
    repeat (10) @(posedge pclk);
    debug_halt <= 1'b1;
    rd(OFF_COUNT, 33'h4);
    rd(OFF_STATUS, 33'h1);
    chk_irq(1'b1);
    xfer(1'b1, OFF_MASK, 32'h0);
    chk_irq(1'b0);
    xfer(1'b1, OFF_STATUS, 32'h1);
    repeat (20) @(posedge pclk);
    rd(OFF_COUNT, 33'h4);
    i_far.pin(0, 1'b1);
    repeat (3) @(posedge pclk);
    rd(OFF_VAL0, 33'h4);
    rd(OFF_STATUS, 33'h2);
    // Pin outputs with the time base held at 4
    xfer(1'b1, OFF_MODE0 + 8'h04, 32'h05);  // PWM16
    xfer(1'b1, OFF_MODE0 + 8'h08, 32'h04);  // PWM8
    xfer(1'b1, OFF_MODE0 + 8'h0C, 32'h03);  // Toggle on match
    xfer(1'b1, OFF_VAL0 + 8'h04, 32'h10);
    xfer(1'b1, OFF_VAL0 + 8'h08, 32'h1203);
    xfer(1'b1, OFF_VAL0 + 8'h0C, 32'h08);
    chk_pin(1, 1'b1);
    chk_pin(2, 1'b0);
    chk_pin(3, 1'b0);
    debug_halt <= 1'b0;
    repeat (10) @(posedge pclk);
    debug_halt <= 1'b1;
    chk_pin(3, 1'b1);
    rd(OFF_STATUS, 33'h12);
    // Every counter clock source
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, OFF_CTRL, 32'(src_a[i] * 2 + 1));
      xfer(1'b1, OFF_COUNT, 32'h0);
      debug_halt <= 1'b0;
      if (knd_a[i] == 3) repeat (n_a[i]) @(posedge pclk);
      else i_far.burst(knd_a[i], n_a[i]);
      if (knd_a[i] != 3) repeat (8) @(posedge pclk);
      debug_halt <= 1'b1;
      rd(OFF_COUNT, 33'(exp_a[i]));
    end
    // Watchdog timeout pulse, then permanent lock
    debug_halt <= 1'b0;
    xfer(1'b1, OFF_WDOG, 32'h1);
    xfer(1'b1, OFF_CTRL, 32'h08);
    xfer(1'b1, OFF_VAL0 + 8'h10, 32'h40);
    xfer(1'b1, OFF_COUNT, 32'h0);
    n = 0;
    while (wd_reset_req !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= 60 && n <= 68, 1'b1)
    @(posedge pclk);
    `CHK(wd_reset_req, 1'b0)
    xfer(1'b1, OFF_WDOG, 32'h2);
    xfer(1'b1, OFF_WDOG, 32'h0);
    rd(OFF_WDOG, 33'h3);
    // Second reset mid-run clears lock, re-arms watchdog
    do_reset();
    rd(OFF_WDOG, 33'h1);
    rd(OFF_VAL0 + 8'h10, {17'h0, WD_VAL_RST});
    repeat (2) @(posedge pclk);
    final_report();
  end
endmodule
`default_nettype wire
